// file: dsm_slave.sv
// dsm_slave: debug serial slave giving word access to a 16-bit memory space
// assumes: link pins asynchronous to clk; sclk well below clk/4; memory write/read
//          ports are on clk and read data is valid one cycle after mem_rd_req
// Behaviour
// - select high two clocks resets serial state
// - eight-bit command shifted first after select
// - sixteen-bit address follows the command
// - sixteen-bit data words follow the address
// - master holds select low whole transaction
// - slave samples command line on rising edges
// - slave changes return line on falling edges
// - master alone generates the serial clock
// - command 02 writes first word at address
// - further write words go to incremented address
// - command 03 returns check word then data
// - check word is command then address high byte
// - further reads return next consecutive addresses
// - idle return line shows processor halted
// - works whether processor runs or halts
`timescale 1ns/100ps
`default_nettype none
module dsm_slave
  import dsm_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  dsm_link_if.slave        link,
  input  wire logic        cpu_halted,
  output logic             mem_wr_req,
  output logic [15:0]      mem_wr_addr,
  output logic [15:0]      mem_wr_data,
  output logic             mem_rd_req,
  output logic [15:0]      mem_rd_addr,
  input  wire logic [15:0] mem_rd_data
);
  typedef enum logic [1:0] {DSM_S_CMD = 2'b00, DSM_S_ADDR = 2'b01, DSM_S_DATA = 2'b11} dsm_sstate_e;

  logic [2:0]  sclk_s_q, cs_s_q, mosi_s_q;
  logic [2:0]  sclk_s_d, cs_s_d, mosi_s_d;
  dsm_sstate_e st_q, st_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [7:0]  cmd_q, cmd_d;
  logic [15:0] sh_q, sh_d;
  logic [15:0] addr_q, addr_d;
  logic [15:0] tx_q, tx_d;
  logic        miso_q, miso_d;
  logic        rs_q, rs_d;
  logic [1:0]  hi_cnt_q, hi_cnt_d;
  logic        wr_q, wr_d;
  logic        rd_q, rd_d;
  logic        load_q, load_d;
  logic        first_q, first_d;
  logic [15:0] wa_q, wa_d;
  logic [15:0] wd_q, wd_d;
  logic        sclk_rise, sclk_fall, sel;
  logic [15:0] word_in;

  assign sclk_rise = sclk_s_q[1] & ~sclk_s_q[2];
  assign sclk_fall = ~sclk_s_q[1] & sclk_s_q[2];
  assign sel       = ~cs_s_q[1];
  assign word_in   = {sh_q[14:0], mosi_s_q[1]};

  always_comb
  begin
    sclk_s_d = {sclk_s_q[1:0], link.sclk};
    cs_s_d   = {cs_s_q[1:0], link.cs_n};
    mosi_s_d = {mosi_s_q[1:0], link.mosi};
    st_d     = st_q;
    cnt_d    = cnt_q;
    cmd_d    = cmd_q;
    sh_d     = sh_q;
    addr_d   = addr_q;
    tx_d     = tx_q;
    miso_d   = miso_q;
    rs_d     = rs_q;
    hi_cnt_d = hi_cnt_q;
    wr_d     = 1'b0;
    rd_d     = 1'b0;
    load_d   = 1'b0;
    first_d  = first_q;
    wa_d     = wa_q;
    wd_d     = wd_q;
    if (!sel)
    begin
      // select high: partial words dropped, framing restarts
      st_d  = DSM_S_CMD;
      cnt_d = 4'h0;
      miso_d = cpu_halted;
      if (sclk_rise && hi_cnt_q != 2'(DSM_RESET_CLKS))
        hi_cnt_d = hi_cnt_q + 2'h1;
      if (hi_cnt_d == 2'(DSM_RESET_CLKS))
      begin
        // reset sequence also clears leftover data-phase state
        rs_d    = 1'b1;
        first_d = 1'b0;
      end
    end
    else
    begin
      hi_cnt_d = 2'h0;
      if (sclk_rise)
      begin
        sh_d  = word_in;
        cnt_d = cnt_q + 4'h1;
        unique case (st_q)
          DSM_S_CMD:
            if (cnt_q == 4'(DSM_CMD_W - 1))
            begin
              cmd_d = word_in[7:0];
              st_d  = DSM_S_ADDR;
              cnt_d = 4'h0;
            end
          DSM_S_ADDR:
            if (cnt_q == 4'(DSM_ADDR_W - 1))
            begin
              addr_d  = word_in;
              st_d    = DSM_S_DATA;
              first_d = 1'b1;
              if (cmd_q == DSM_CMD_READ)
              begin
                tx_d = {cmd_q, word_in[15:8]};
                rd_d = 1'b1;
              end
            end
          DSM_S_DATA:
            if (cnt_q == 4'(DSM_DATA_W - 1))
            begin
              if (cmd_q == DSM_CMD_WRITE)
              begin
                wr_d   = 1'b1;
                wa_d   = addr_q;
                wd_d   = word_in;
                addr_d = addr_q + 16'h1;
              end
              else if (cmd_q == DSM_CMD_READ)
              begin
                if (!first_q)
                  addr_d = addr_q + 16'h1;
                rd_d = 1'b1;
              end
              first_d = 1'b0;
            end
          default:
            st_d = DSM_S_CMD;
        endcase
      end
      if (rd_q && !first_q)
        load_d = 1'b1;
      if (load_q)
        tx_d = mem_rd_data;
      if (sclk_fall && st_q == DSM_S_DATA && cmd_q == DSM_CMD_READ)
      begin
        miso_d = tx_q[15];
        tx_d   = load_q ? mem_rd_data : {tx_q[14:0], 1'b0};
      end
      else if (sclk_fall && first_q)
        miso_d = 1'b0;
      if (rs_q)
        rs_d = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_s_q <= 3'h0;
      cs_s_q   <= 3'h7;
      mosi_s_q <= 3'h0;
      st_q     <= DSM_S_CMD;
      cnt_q    <= 4'h0;
      cmd_q    <= 8'h00;
      sh_q     <= DSM_DATA_RST;
      addr_q   <= DSM_ADDR_RST;
      tx_q     <= DSM_DATA_RST;
      miso_q   <= 1'b0;
      rs_q     <= 1'b0;
      hi_cnt_q <= 2'h0;
      wr_q     <= 1'b0;
      rd_q     <= 1'b0;
      load_q   <= 1'b0;
      first_q  <= 1'b0;
      wa_q     <= DSM_ADDR_RST;
      wd_q     <= DSM_DATA_RST;
    end
    else
    begin
      sclk_s_q <= sclk_s_d;
      cs_s_q   <= cs_s_d;
      mosi_s_q <= mosi_s_d;
      st_q     <= st_d;
      cnt_q    <= cnt_d;
      cmd_q    <= cmd_d;
      sh_q     <= sh_d;
      addr_q   <= addr_d;
      tx_q     <= tx_d;
      miso_q   <= miso_d;
      rs_q     <= rs_d;
      hi_cnt_q <= hi_cnt_d;
      wr_q     <= wr_d;
      rd_q     <= rd_d;
      load_q   <= load_d;
      first_q  <= first_d;
      wa_q     <= wa_d;
      wd_q     <= wd_d;
    end
  end

  // read after address is not loaded; read after check word fetches addr, later ones follow the increment
  assign mem_rd_req  = rd_q;
  assign mem_rd_addr = addr_q;
  assign mem_wr_req  = wr_q;
  assign mem_wr_addr = wa_q;
  assign mem_wr_data = wd_q;
  assign link.miso   = miso_q;
endmodule
`default_nettype wire

// file: dsm_pkg.sv
// dsm_pkg: shared constants for the debug serial memory port
// assumes: both ends compiled against this package
`default_nettype none
package dsm_pkg;
  localparam int          DSM_CMD_W      = 8;
  localparam int          DSM_ADDR_W     = 16;
  localparam int          DSM_DATA_W     = 16;
  localparam logic [7:0]  DSM_CMD_WRITE  = 8'h02;
  localparam logic [7:0]  DSM_CMD_READ   = 8'h03;
  localparam int          DSM_RESET_CLKS = 2;
  localparam logic [5:0]  DSM_HALF_DIV   = 6'h08;
  localparam logic [15:0] DSM_ADDR_RST   = 16'h0000;
  localparam logic [15:0] DSM_DATA_RST   = 16'h0000;
endpackage
`default_nettype wire

// file: dsm_link_if.sv
// dsm_link_if: serial debug link between master and slave
// assumes: master drives clock, select and command line; slave drives return line
`timescale 1ns/100ps
`default_nettype none
interface dsm_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  modport slave  (input sclk, input cs_n, input mosi, output miso);
  modport master (output sclk, output cs_n, output mosi, input miso);
endinterface
`default_nettype wire

// file: dsm_master.sv
// dsm_master: debug serial master issuing single or burst word accesses
// assumes: user holds request until busy or wdata_take; return line asynchronous to clk
`timescale 1ns/100ps
`default_nettype none
module dsm_master
  import dsm_pkg::*;
#(
  parameter int MAX_WORDS = 256
)
(
  input  wire logic        clk,
  input  wire logic        resetn,
  dsm_link_if.master       link,
  input  wire logic        start,
  input  wire logic        is_read,
  input  wire logic [15:0] addr,
  input  wire logic [8:0]  nwords,
  input  wire logic [15:0] wdata,
  output logic             wdata_take,
  output logic [15:0]      rdata,
  output logic             rdata_valid,
  output logic [15:0]      check_word,
  output logic             busy,
  output logic             done,
  output logic             idle_halted
);
  typedef enum logic [2:0] {DSM_M_IDLE = 3'b000, DSM_M_RST = 3'b001, DSM_M_SHIFT = 3'b011,
                            DSM_M_END = 3'b010} dsm_mstate_e;

  dsm_mstate_e st_q, st_d;
  logic [5:0]  div_q, div_d;
  logic        sclk_q, sclk_d;
  logic        cs_n_q, cs_n_d;
  logic        mosi_q, mosi_d;
  logic [39:0] sh_q, sh_d;
  logic [5:0]  bit_q, bit_d;
  logic [8:0]  left_q, left_d;
  logic        rd_q, rd_d;
  logic        chk_q, chk_d;
  logic [15:0] rx_q, rx_d;
  logic [15:0] rdata_q, rdata_d;
  logic        rv_q, rv_d;
  logic [15:0] chkw_q, chkw_d;
  logic        take_q, take_d;
  logic        done_q, done_d;
  logic [1:0]  miso_s_q, miso_s_d;
  logic [1:0]  rcnt_q, rcnt_d;
  logic        tick;

  assign tick = (div_q == DSM_HALF_DIV - 6'h1);

  always_comb
  begin
    st_d = st_q; div_d = tick ? 6'h0 : div_q + 6'h1;
    sclk_d = sclk_q; cs_n_d = cs_n_q; mosi_d = mosi_q; sh_d = sh_q;
    bit_d = bit_q; left_d = left_q; rd_d = rd_q; chk_d = chk_q;
    rx_d = rx_q; rdata_d = rdata_q; rv_d = 1'b0; chkw_d = chkw_q;
    take_d = 1'b0; done_d = 1'b0; rcnt_d = rcnt_q;
    miso_s_d = {miso_s_q[0], link.miso};
    unique case (st_q)
      DSM_M_IDLE:
        if (start && tick)
        begin
          st_d = DSM_M_RST; rcnt_d = 2'h0; rd_d = is_read;
          // burst length clamped to what the user side can feed
          left_d = (nwords == 9'h0) ? 9'h1 : (nwords > 9'(MAX_WORDS)) ? 9'(MAX_WORDS) : nwords;
          sh_d = {is_read ? DSM_CMD_READ : DSM_CMD_WRITE, addr, wdata};
          take_d = ~is_read;
        end
      DSM_M_RST:
        if (tick)
        begin
          sclk_d = ~sclk_q;
          if (sclk_q && rcnt_q == 2'(DSM_RESET_CLKS - 1))
          begin
            st_d = DSM_M_SHIFT; cs_n_d = 1'b0; bit_d = 6'h0; chk_d = rd_q;
            mosi_d = sh_q[39];
          end
          else if (sclk_q)
            rcnt_d = rcnt_q + 2'h1;
        end
      DSM_M_SHIFT:
        if (tick)
        begin
          sclk_d = ~sclk_q;
          if (!sclk_q)
          begin
            // rising edge: slave samples mosi, master samples miso
            rx_d = {rx_q[14:0], miso_s_q[1]};
            bit_d = bit_q + 6'h1;
            if (bit_q >= 6'd24 && bit_q[3:0] == 4'h7)
            begin
              if (rd_q && chk_q)
              begin
                chkw_d = {rx_q[14:0], miso_s_q[1]}; chk_d = 1'b0;
              end
              else
              begin
                if (rd_q)
                begin
                  rdata_d = {rx_q[14:0], miso_s_q[1]}; rv_d = 1'b1;
                end
                left_d = left_q - 9'h1;
                if (left_q == 9'h1)
                  st_d = DSM_M_END;
              end
              bit_d = 6'd24;
              if (!rd_q && left_q != 9'h1)
              begin
                sh_d[39:24] = wdata; take_d = 1'b1;
              end
            end
            else
              sh_d = {sh_q[38:0], 1'b0};
          end
          else
            mosi_d = sh_q[39];
        end
      DSM_M_END:
        if (tick)
        begin
          cs_n_d = 1'b1; sclk_d = 1'b0; st_d = DSM_M_IDLE; done_d = 1'b1;
        end
      default:
        st_d = DSM_M_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_q <= DSM_M_IDLE; div_q <= 6'h0; sclk_q <= 1'b0; cs_n_q <= 1'b1;
      mosi_q <= 1'b0; sh_q <= 40'h0; bit_q <= 6'h0; left_q <= 9'h0;
      rd_q <= 1'b0; chk_q <= 1'b0; rx_q <= 16'h0; rdata_q <= 16'h0;
      rv_q <= 1'b0; chkw_q <= 16'h0; take_q <= 1'b0; done_q <= 1'b0;
      miso_s_q <= 2'h0; rcnt_q <= 2'h0;
    end
    else
    begin
      st_q <= st_d; div_q <= div_d; sclk_q <= sclk_d; cs_n_q <= cs_n_d;
      mosi_q <= mosi_d; sh_q <= sh_d; bit_q <= bit_d; left_q <= left_d;
      rd_q <= rd_d; chk_q <= chk_d; rx_q <= rx_d; rdata_q <= rdata_d;
      rv_q <= rv_d; chkw_q <= chkw_d; take_q <= take_d; done_q <= done_d;
      miso_s_q <= miso_s_d; rcnt_q <= rcnt_d;
    end
  end

  assign link.sclk   = sclk_q;
  assign link.cs_n   = cs_n_q;
  assign link.mosi   = mosi_q;
  assign wdata_take  = take_q;
  assign rdata       = rdata_q;
  assign rdata_valid = rv_q;
  assign check_word  = chkw_q;
  assign busy        = (st_q != DSM_M_IDLE);
  assign done        = done_q;
  assign idle_halted = miso_s_q[1] & cs_n_q;
endmodule
`default_nettype wire

// file: dsm_link_monitor.sv
// dsm_link_monitor: framing and timing checks on the serial debug link
// assumes: link signals sampled on clk; instantiated beside the link interface
`timescale 1ns/100ps
`default_nettype none
module dsm_link_monitor
  import dsm_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic cpu_halted,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso
);
  logic        sclk_q;
  logic        rise;
  logic [9:0]  cnt_q, cnt_d;
  logic [3:0]  hi_q, hi_d;
  logic [39:0] sh_q, sh_d;
  logic [15:0] ms_q, ms_d;

  assign rise = sclk && !sclk_q;
  // rising serial edges counted per frame and while deselected
  always_comb
  begin
    cnt_d = cs_n ? 10'h000 : cnt_q + {9'h000, rise};
    hi_d  = !cs_n ? 4'h0 : hi_q + {3'h0, rise && hi_q != 4'hf};
    sh_d  = (rise && !cs_n) ? {sh_q[38:0], mosi} : sh_q;
    ms_d  = (rise && !cs_n) ? {ms_q[14:0], miso} : ms_q;
  end
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      sclk_q <= 1'b0;
      cnt_q  <= 10'h000;
      hi_q   <= 4'h0;
      sh_q   <= 40'h0;
      ms_q   <= 16'h0000;
    end
    else
    begin
      sclk_q <= sclk;
      cnt_q  <= cnt_d;
      hi_q   <= hi_d;
      sh_q   <= sh_d;
      ms_q   <= ms_d;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  AST_SER_RESET: assert property ($fell(cs_n) |-> hi_q >= 4'h2)
    else $error("select fell without two reset clocks");
  AST_FRAME_LEN: assert property ($rose(cs_n) |-> cnt_q >= 10'd40 && cnt_q[3:0] == 4'h8)
    else $error("frame length not command, address and whole words");
  AST_CS_EDGE: assert property ($changed(cs_n) |-> !sclk)
    else $error("select changed while serial clock high");
  AST_MOSI_HOLD: assert property (sclk && !cs_n |-> $stable(mosi))
    else $error("command line moved while serial clock high");
  AST_MISO_FALL: assert property (!cs_n && !$past(cs_n, 6) && $changed(miso) |-> !sclk)
    else $error("return line moved while serial clock high");
  AST_SCLK_HIGH: assert property ($rose(sclk) |-> sclk[*8] ##1 !sclk)
    else $error("serial clock high phase not eight cycles");
  AST_SCLK_LOW: assert property ($fell(sclk) |-> !sclk[*8])
    else $error("serial clock low phase too short");
  AST_CHECK_WORD: assert property ($rose(cnt_q == 10'd40) && sh_q[39:32] == DSM_CMD_READ
    |-> ms_q == {DSM_CMD_READ, sh_q[31:24]})
    else $error("check word on return line wrong");
  AST_IDLE_LEVEL: assert property (cs_n && $past(cs_n, 4) && $past(cpu_halted, 3) == cpu_halted
    |-> miso == cpu_halted)
    else $error("idle return line does not show processor state");
endmodule
`default_nettype wire

// file: tb_debug_spi_memory_slave.sv
// tb_debug_spi_memory_slave: master and slave joined over the link, memory model on slave side
// assumes: dsm_pkg, dsm_link_if, dsm_master, dsm_slave and dsm_link_monitor compiled first
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) \
  begin \
    checked++; \
    if ((a) !== (b)) \
    begin \
      miscompares++; \
      $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); \
    end \
  end
module tb_debug_spi_memory_slave
  import dsm_pkg::*;
;
  logic        clk = 1'b0, resetn = 1'b0, start = 1'b0, is_read = 1'b0, cpu_halted = 1'b0;
  logic [15:0] addr = 16'h0000, wdata = 16'h0000, mem_rd_data = 16'h0000;
  logic [8:0]  nwords = 9'h000;
  logic        wdata_take, rdata_valid, busy, done, idle_halted, mem_wr_req, mem_rd_req;
  logic [15:0] rdata, check_word, mem_wr_addr, mem_wr_data, mem_rd_addr, mb;
  logic [15:0] mem [64];
  logic [23:0] hb;
  logic [15:0] rq[$], wq[$];
  int          miscompares = 0, checked = 0, cyc = 0, nb = 0;

  dsm_link_if link();
  dsm_master #(.MAX_WORDS(8)) dsm_master_inst (.clk(clk), .resetn(resetn), .link(link), .start(start),
    .is_read(is_read), .addr(addr), .nwords(nwords), .wdata(wdata), .wdata_take(wdata_take), .rdata(rdata),
    .rdata_valid(rdata_valid), .check_word(check_word), .busy(busy), .done(done), .idle_halted(idle_halted));
  dsm_slave dsm_slave_inst (.clk(clk), .resetn(resetn), .link(link), .cpu_halted(cpu_halted),
    .mem_wr_req(mem_wr_req), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .mem_rd_req(mem_rd_req), .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data));
  dsm_link_monitor dsm_link_monitor_inst (.clk(clk), .resetn(resetn), .cpu_halted(cpu_halted),
    .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso));

  always #2 clk = ~clk;

  // memory answers one cycle after the read request
  always @(posedge clk)
  begin
    if (mem_wr_req === 1'b1)
      mem[mem_wr_addr[5:0]] <= mem_wr_data;
    if (mem_rd_req === 1'b1)
      mem_rd_data <= mem[mem_rd_addr[5:0]];
  end

  always @(negedge clk)
  begin
    if (rdata_valid === 1'b1)
      rq.push_back(rdata);
    if (wdata_take === 1'b1)
    begin
      void'(wq.pop_front());
      @(posedge clk);
      #1;
      wdata = wq.size() > 0 ? wq[0] : 16'h0000;
    end
  end

  // wire capture: header bits in, check word out
  // reset clocks with select high restart the bit count
  always @(posedge link.sclk)
    if (link.cs_n)
      nb = 0;
    else
    begin
      if (nb < 24)
        hb = {hb[22:0], link.mosi};
      else if (nb < 40)
        mb = {mb[14:0], link.miso};
      nb++;
    end

  task automatic test_done();
    $display("checked=%0d miscompares=%0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic xfer(input logic rd, input logic [15:0] a, input logic [8:0] n);
    @(posedge clk);
    #1;
    start   = 1'b1;
    is_read = rd;
    addr    = a;
    nwords  = n;
    wdata   = wq.size() > 0 ? wq[0] : 16'h0000;
    while (busy !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    #1;
    start = 1'b0;
    while (done !== 1'b1)
      @(negedge clk);
    repeat (20)
      @(posedge clk);
    #1;
  endtask

  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      miscompares++;
      test_done();
    end
  end

  initial
  begin
    repeat (6)
      @(posedge clk);
    #1;
    resetn = 1'b1;
    wq = '{16'hbeef, 16'h1234, 16'ha5c3};
    xfer(1'b0, 16'h12fe, 9'h003);
    `CHK(hb, {DSM_CMD_WRITE, 16'h12fe})
    `CHK(nb, 72)
    `CHK(mem[6'h3e], 16'hbeef)
    `CHK(mem[6'h3f], 16'h1234)
    `CHK(mem[6'h00], 16'ha5c3)
    $display("test burst write done");
    `CHK(link.miso, 1'b0)
    `CHK(idle_halted, 1'b0)
    cpu_halted = 1'b1;
    repeat (10)
      @(posedge clk);
    #1;
    `CHK(link.miso, 1'b1)
    `CHK(idle_halted, 1'b1)
    $display("test idle level done");
    rq.delete();
    xfer(1'b1, 16'h12fe, 9'h003);
    `CHK(check_word, {DSM_CMD_READ, 8'h12})
    `CHK(mb, {DSM_CMD_READ, 8'h12})
    `CHK(rq.size(), 3)
    `CHK(rq[0], 16'hbeef)
    `CHK(rq[1], 16'h1234)
    `CHK(rq[2], 16'ha5c3)
    $display("test burst read halted done");
    cpu_halted = 1'b0;
    wq = '{16'h0f0f};
    xfer(1'b0, 16'h0005, 9'h001);
    `CHK(mem[6'h05], 16'h0f0f)
    rq.delete();
    xfer(1'b1, 16'h0005, 9'h000);
    `CHK(hb, {DSM_CMD_READ, 16'h0005})
    `CHK(rq.size(), 1)
    `CHK(rq[0], 16'h0f0f)
    $display("test single word done");
    test_done();
  end
endmodule
`default_nettype wire
